// File: design/rtc_irq_pkg.sv
package rtc_irq_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h01;
  localparam logic [7:0] ADDR_MINUTES    = 8'h03;
  localparam logic [7:0] ADDR_HOURS      = 8'h04;
  localparam logic [7:0] ADDR_DATE       = 8'h05;
  localparam logic [7:0] ADDR_WEEKDAY    = 8'h06;
  localparam logic [7:0] ADDR_MIN_ALARM  = 8'h09;
  localparam logic [7:0] ADDR_HOUR_ALARM = 8'h0a;
  localparam logic [7:0] ADDR_DATE_ALARM = 8'h0b;
  localparam logic [7:0] ADDR_WDAY_ALARM = 8'h0c;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_TIMER_PRE  = 8'h0f;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int BIT_TIMER_IRQ_EN   = 0;
  localparam int BIT_ALARM_IRQ_EN   = 1;
  localparam int BIT_TIMER_FLAG     = 2;
  localparam int BIT_ALARM_FLAG     = 3;
  localparam int BIT_TIMER_REPEAT   = 4;
  localparam int BIT_TIMER_RUN      = 7;
  localparam int BIT_ALARM_MASK     = 7;
  localparam logic [7:0] MIN_FIELD  = 8'h7f;
  localparam logic [7:0] HOUR_FIELD = 8'h3f;
  localparam logic [7:0] DATE_FIELD = 8'h3f;
  localparam logic [7:0] WDAY_FIELD = 8'h07;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] RST_ALARM     = 8'h80;
  localparam int         CLK_HZ        = 50_000_000;
  localparam int         PULSE_HOLD_NS = 1000;
  localparam int         PULSE_HOLD_CYC_I =
    (PULSE_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [15:0] PULSE_HOLD_CYC = PULSE_HOLD_CYC_I[15:0];

  // Source clock selection codes.
  typedef enum logic [1:0] {
    SRC_4096HZ = 2'b00,
    SRC_64HZ   = 2'b01,
    SRC_1HZ    = 2'b10,
    SRC_1MIN   = 2'b11
  } src_sel_t;

endpackage

// File: design/irq_evt_if.sv
`timescale 1ns/1ps
// Carries the one-cycle event pulses from the two detectors to the core.
interface irq_evt_if;
  logic timer_evt;
  logic alarm_evt;
  modport timer_src (output timer_evt);
  modport alarm_src (output alarm_evt);
  modport sink      (input timer_evt, input alarm_evt);
endinterface : irq_evt_if

// File: design/timer_countdown.sv
`timescale 1ns/1ps
module timer_countdown
  import rtc_irq_pkg::*;
(
  input  wire logic       clk,     // System clock.
  input  wire logic       sys_rst, // Synchronous reset, active high.
  input  wire logic       run_en,  // Timer run enable.
  input  wire src_sel_t   src_sel, // Source clock select.
  input  wire logic [3:0] ticks,   // One-cycle source ticks, indexed by select code.
  input  wire logic [7:0] preset,  // Preset countdown value.
  irq_evt_if.timer_src    evt      // Event pulse out.
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       run_q;
  logic       start;
  logic       tick;
  logic       hit;

  // ----------------------------------------------------------------------
  // Tick selection and event decode
  // ----------------------------------------------------------------------
  assign tick  = ticks[src_sel];
  assign start = run_en & ~run_q;
  assign hit   = run_en & run_q & tick & (cnt_q == 8'h01);
  assign evt.timer_evt = hit;

  // Reload on start and right after an event, so a zero preset never fires.
  always_comb
  begin
    cnt_d = cnt_q;
    if (start)
      cnt_d = preset;
    else if (hit)
      cnt_d = preset;
    else if (run_en & tick & (cnt_q != 8'h00))
      cnt_d = cnt_q - 8'h01;
    else if (~run_en)
      cnt_d = cnt_q;
  end

  // Counter state.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= RST_BYTE;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_en;
    end
  end

endmodule // timer_countdown

// File: design/alarm_compare.sv
`timescale 1ns/1ps
module alarm_compare
  import rtc_irq_pkg::*;
(
  input  wire logic [7:0] cur_min,    // Current minutes, BCD.
  input  wire logic [7:0] cur_hour,   // Current hours, BCD.
  input  wire logic [7:0] cur_date,   // Current date, BCD.
  input  wire logic [7:0] cur_wday,   // Current weekday.
  input  wire logic [7:0] alm_min,    // Minute alarm setting with mask.
  input  wire logic [7:0] alm_hour,   // Hour alarm setting with mask.
  input  wire logic [7:0] alm_date,   // Date alarm setting with mask.
  input  wire logic [7:0] alm_wday,   // Weekday alarm setting with mask.
  output logic            match       // Level: all unmasked fields agree and at least one field is unmasked.
);

  // One field agrees when masked out or equal within its valid BCD bits.
  function automatic logic field_ok(input logic [7:0] cur, input logic [7:0] alm,
                                    input logic [7:0] fld);
    field_ok = alm[BIT_ALARM_MASK] | ((cur & fld) == (alm & fld));
  endfunction

  logic all_masked;
  logic fields_ok;

  // ----------------------------------------------------------------------
  // Match decode
  // ----------------------------------------------------------------------
  assign all_masked = alm_min[BIT_ALARM_MASK] & alm_hour[BIT_ALARM_MASK] &
                      alm_date[BIT_ALARM_MASK] & alm_wday[BIT_ALARM_MASK];
  assign fields_ok  = field_ok(cur_min, alm_min, MIN_FIELD) &
                      field_ok(cur_hour, alm_hour, HOUR_FIELD) &
                      field_ok(cur_date, alm_date, DATE_FIELD) &
                      field_ok(cur_wday, alm_wday, WDAY_FIELD);
  assign match = fields_ok & ~all_masked;

endmodule // alarm_compare

// File: design/rtc_timer_alarm_irq.sv
`timescale 1ns/1ps
module rtc_timer_alarm_irq
  import rtc_irq_pkg::*;
(
  input  wire logic       clk,         // 50 MHz system clock.
  input  wire logic       sys_rst,     // Synchronous reset, active high.
  input  wire logic       reg_wr,      // Register write strobe, one cycle.
  input  wire logic       reg_rd,      // Register read strobe, one cycle.
  input  wire logic [7:0] reg_addr,    // Register offset.
  input  wire logic [7:0] reg_wdata,   // Write data.
  output logic      [7:0] reg_rdata,   // Read data, valid the cycle after reg_rd.
  input  wire logic       tick_4096hz, // 4096 Hz source tick, one cycle.
  input  wire logic       tick_64hz,   // 64 Hz source tick, one cycle.
  input  wire logic       tick_1hz,    // Seconds update tick, one cycle.
  input  wire logic       tick_1min,   // Minutes update tick, one cycle.
  input  wire logic       time_upd,    // Timekeeping load strobe for the time fields.
  input  wire logic [7:0] new_min,     // Minutes from timekeeping, BCD.
  input  wire logic [7:0] new_hour,    // Hours from timekeeping, BCD.
  input  wire logic [7:0] new_date,    // Date from timekeeping, BCD.
  input  wire logic [7:0] new_wday,    // Weekday from timekeeping.
  output logic            int_n_out,   // Interrupt pin output value, always 0.
  output logic            int_n_oe_n,  // Interrupt pin enable, low while pulling low.
  output logic            timer_irq_n, // Timer share of the line, active low.
  output logic            alarm_irq_n  // Alarm share of the line, active low.
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  // Time fields keep only their valid bits; alarms keep the mask bit too.
  logic       timer_irq_en_q;
  logic       alarm_irq_en_q;
  logic       timer_event_flag_q;
  logic       alarm_event_flag_q;
  logic       timer_repeat_mode_sel_q;
  logic       timer_run_en_q;
  src_sel_t   src_sel_q;
  logic [7:0] timer_preset_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [7:0] date_q;
  logic [7:0] wday_q;
  logic [7:0] alm_min_q;
  logic [7:0] alm_hour_q;
  logic [7:0] alm_date_q;
  logic [7:0] alm_wday_q;
  logic [7:0] reg_rdata_q;
  logic       match_q;
  logic [15:0] hold_q;
  logic [15:0] hold_d;
  logic       timer_flag_d;
  logic       alarm_flag_d;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_tctl;
  logic wr_pre;
  logic wr_min;
  logic wr_hour;
  logic wr_date;
  logic wr_wday;
  logic wr_amin;
  logic wr_ahour;
  logic wr_adate;
  logic wr_awday;

  // Each strobe is qualified once here so the register processes stay short.
  assign wr_ctrl  = reg_wr & (reg_addr == ADDR_IRQ_CTRL);
  assign wr_tctl  = reg_wr & (reg_addr == ADDR_TIMER_CTRL);
  assign wr_pre   = reg_wr & (reg_addr == ADDR_TIMER_PRE);
  assign wr_min   = reg_wr & (reg_addr == ADDR_MINUTES);
  assign wr_hour  = reg_wr & (reg_addr == ADDR_HOURS);
  assign wr_date  = reg_wr & (reg_addr == ADDR_DATE);
  assign wr_wday  = reg_wr & (reg_addr == ADDR_WEEKDAY);
  assign wr_amin  = reg_wr & (reg_addr == ADDR_MIN_ALARM);
  assign wr_ahour = reg_wr & (reg_addr == ADDR_HOUR_ALARM);
  assign wr_adate = reg_wr & (reg_addr == ADDR_DATE_ALARM);
  assign wr_awday = reg_wr & (reg_addr == ADDR_WDAY_ALARM);

  // ----------------------------------------------------------------------
  // Event detectors
  // ----------------------------------------------------------------------
  // Detectors hand one-cycle event pulses to the flag logic here.
  irq_evt_if evt_bus ();

  logic [3:0] ticks;
  logic       match;
  logic       alarm_hit;

  // Tick vector is ordered by the source select code.
  assign ticks = {tick_1min, tick_1hz, tick_64hz, tick_4096hz};

  // The counter reloads on every event, in either mode.
  timer_countdown u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run_en  (timer_run_en_q),
    .src_sel (src_sel_q),
    .ticks   (ticks),
    .preset  (timer_preset_q),
    .evt     (evt_bus.timer_src)
  );

  // The compare is a level; its entry edge is taken below.
  alarm_compare u_alarm (
    .cur_min  (min_q),
    .cur_hour (hour_q),
    .cur_date (date_q),
    .cur_wday (wday_q),
    .alm_min  (alm_min_q),
    .alm_hour (alm_hour_q),
    .alm_date (alm_date_q),
    .alm_wday (alm_wday_q),
    .match    (match)
  );

  // Only the entry into a match is an event; a match held for a whole minute
  // would otherwise re-set the flag right after software cleared it.
  assign alarm_hit = match & ~match_q;
  assign evt_bus.alarm_evt = alarm_hit;

  // ----------------------------------------------------------------------
  // Flag next values: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------------
  logic clr_timer_flag;
  logic clr_alarm_flag;

  // Only a 0 clears a flag, so writing back a 1 just read loses nothing.
  assign clr_timer_flag = wr_ctrl & ~reg_wdata[BIT_TIMER_FLAG];
  assign clr_alarm_flag = wr_ctrl & ~reg_wdata[BIT_ALARM_FLAG];

  // The set comes last, so a clear cannot swallow an event of that cycle.
  always_comb
  begin
    timer_flag_d = timer_event_flag_q;
    alarm_flag_d = alarm_event_flag_q;
    if (clr_timer_flag)
      timer_flag_d = 1'b0;
    if (clr_alarm_flag)
      alarm_flag_d = 1'b0;
    if (evt_bus.timer_evt)
      timer_flag_d = 1'b1;
    if (evt_bus.alarm_evt)
      alarm_flag_d = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Repeat mode pulse hold counter
  // ----------------------------------------------------------------------
  logic hold_start;
  logic hold_busy;

  // A pulse starts only for an enabled event in repeat mode.
  assign hold_start = evt_bus.timer_evt & timer_irq_en_q & timer_repeat_mode_sel_q;
  assign hold_busy  = (hold_q != 16'h0000);

  // The counter ignores flag writes and run enable, so neither of them can cut the pulse.
  always_comb
  begin
    hold_d = hold_q;
    if (hold_start)
      hold_d = PULSE_HOLD_CYC;
    else if (hold_busy)
      hold_d = hold_q - 16'h0001;
  end

  // ----------------------------------------------------------------------
  // Event state: flags, pulse hold and match history
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      timer_event_flag_q <= 1'b0;
      alarm_event_flag_q <= 1'b0;
      hold_q             <= 16'h0000;
      match_q            <= 1'b0;
    end
    else
    begin
      timer_event_flag_q <= timer_flag_d;
      alarm_event_flag_q <= alarm_flag_d;
      hold_q             <= hold_d;
      match_q            <= match;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Run enable and source share one write, so a restart may change source.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      timer_irq_en_q          <= 1'b0;
      alarm_irq_en_q          <= 1'b0;
      timer_repeat_mode_sel_q <= 1'b0;
      timer_run_en_q          <= 1'b0;
      src_sel_q               <= SRC_4096HZ;
    end
    else
    begin
      if (wr_ctrl)
      begin
        timer_irq_en_q          <= reg_wdata[BIT_TIMER_IRQ_EN];
        alarm_irq_en_q          <= reg_wdata[BIT_ALARM_IRQ_EN];
        timer_repeat_mode_sel_q <= reg_wdata[BIT_TIMER_REPEAT];
      end
      if (wr_tctl)
      begin
        timer_run_en_q <= reg_wdata[BIT_TIMER_RUN];
        src_sel_q      <= src_sel_t'(reg_wdata[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data registers: preset, time fields, alarm settings
  // ----------------------------------------------------------------------
  // The counter takes the preset only on a start or a reload, so a write
  // while running shows at the next reload.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      timer_preset_q <= RST_BYTE;
    else if (wr_pre)
      timer_preset_q <= reg_wdata;
  end

  // Host writes to a time field win over a timekeeping load in the same cycle.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      min_q  <= RST_BYTE;
      hour_q <= RST_BYTE;
      date_q <= RST_BYTE;
      wday_q <= RST_BYTE;
    end
    else
    begin
      if (wr_min)
        min_q <= reg_wdata & MIN_FIELD;
      else if (time_upd)
        min_q <= new_min & MIN_FIELD;
      if (wr_hour)
        hour_q <= reg_wdata & HOUR_FIELD;
      else if (time_upd)
        hour_q <= new_hour & HOUR_FIELD;
      if (wr_date)
        date_q <= reg_wdata & DATE_FIELD;
      else if (time_upd)
        date_q <= new_date & DATE_FIELD;
      if (wr_wday)
        wday_q <= reg_wdata & WDAY_FIELD;
      else if (time_upd)
        wday_q <= new_wday & WDAY_FIELD;
    end
  end

  // Alarms reset masked, so none can fire before the host sets them up.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      alm_min_q  <= RST_ALARM;
      alm_hour_q <= RST_ALARM;
      alm_date_q <= RST_ALARM;
      alm_wday_q <= RST_ALARM;
    end
    else
    begin
      if (wr_amin)
        alm_min_q <= reg_wdata & (MIN_FIELD | 8'h80);
      if (wr_ahour)
        alm_hour_q <= reg_wdata & (HOUR_FIELD | 8'h80);
      if (wr_adate)
        alm_date_q <= reg_wdata & (DATE_FIELD | 8'h80);
      if (wr_awday)
        alm_wday_q <= reg_wdata & (WDAY_FIELD | 8'h80);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_view;
  logic [7:0] tctl_view;
  logic [7:0] rd_mux;

  assign ctrl_view = {3'b000, timer_repeat_mode_sel_q, alarm_event_flag_q,
                      timer_event_flag_q, alarm_irq_en_q, timer_irq_en_q};
  assign tctl_view = {timer_run_en_q, 5'b00000, src_sel_q};

  // Unmapped offsets read as zero.
  always_comb
  begin
    case (reg_addr)
      ADDR_IRQ_CTRL:   rd_mux = ctrl_view;
      ADDR_MINUTES:    rd_mux = min_q;
      ADDR_HOURS:      rd_mux = hour_q;
      ADDR_DATE:       rd_mux = date_q;
      ADDR_WEEKDAY:    rd_mux = wday_q;
      ADDR_MIN_ALARM:  rd_mux = alm_min_q;
      ADDR_HOUR_ALARM: rd_mux = alm_hour_q;
      ADDR_DATE_ALARM: rd_mux = alm_date_q;
      ADDR_WDAY_ALARM: rd_mux = alm_wday_q;
      ADDR_TIMER_CTRL: rd_mux = tctl_view;
      ADDR_TIMER_PRE:  rd_mux = timer_preset_q;
      default:         rd_mux = RST_BYTE;
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  // A write in the same cycle is not yet visible to that read.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata_q <= RST_BYTE;
    else if (reg_rd)
      reg_rdata_q <= rd_mux;
  end

  assign reg_rdata = reg_rdata_q;

  // ----------------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------------
  logic timer_low;
  logic alarm_low;

  // Repeat mode follows the hold counter only; level mode follows flag and enable.
  // The alarm share is combinational so enable or flag changes act at once.
  assign timer_low = timer_repeat_mode_sel_q ? (hold_q != 16'h0000)
                                             : (timer_event_flag_q & timer_irq_en_q);
  assign alarm_low = alarm_event_flag_q & alarm_irq_en_q;

  assign timer_irq_n = ~timer_low;
  assign alarm_irq_n = ~alarm_low;
  // Either share pulls the one line low; neither can ever drive it high.
  assign int_n_out   = 1'b0;                          // Open drain: only ever pulls low.
  assign int_n_oe_n  = ~(timer_low | alarm_low);

endmodule // rtc_timer_alarm_irq

// File: verification/rtc_irq_monitor.sv
`timescale 1ns/1ps
module rtc_irq_monitor
  import rtc_irq_pkg::*;
(
  input wire logic       clk,         // Clock.
  input wire logic       sys_rst,     // Reset.
  input wire logic       reg_wr,      // Write strobe.
  input wire logic [7:0] reg_addr,    // Offset.
  input wire logic [7:0] reg_wdata,   // Write data.
  input wire logic [7:0] reg_rdata,   // Read data.
  input wire logic       tick_4096hz, // Tick.
  input wire logic       tick_64hz,   // Tick.
  input wire logic       tick_1hz,    // Tick.
  input wire logic       tick_1min,   // Tick.
  input wire logic       time_upd,    // Time load.
  input wire logic       int_n_out,   // Pin value.
  input wire logic       int_n_oe_n,  // Pin enable.
  input wire logic       timer_irq_n, // Timer share.
  input wire logic       alarm_irq_n  // Alarm share.
);
  // ---------------------------
  // Helper logic
  // ---------------------------
  logic [15:0] low_q;
  wire         any_tick = tick_4096hz | tick_64hz | tick_1hz | tick_1min;
  wire         any_upd  = reg_wr | time_upd;
  wire         ctrl_wr  = reg_wr && reg_addr == ADDR_IRQ_CTRL;

  // Length of the current timer low pulse; it must not depend on flag writes.
  always_ff @(posedge clk)
    if (sys_rst || timer_irq_n)
      low_q <= 16'h0000;
    else
      low_q <= low_q + 16'h0001;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------
  // Properties
  // ---------------------------
  property p_pin_share;
    int_n_out == 1'b0 && int_n_oe_n == (timer_irq_n && alarm_irq_n);
  endproperty
  a_pin_share: assert property (p_pin_share) else $error("pin not shared");
  property p_rst_idle;
    disable iff (1'b0) sys_rst |=> int_n_oe_n && reg_rdata == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset state wrong");
  property p_hold_len;
    $rose(timer_irq_n) |-> low_q == PULSE_HOLD_CYC;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("pulse length wrong");
  property p_hold_max;
    low_q <= PULSE_HOLD_CYC;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("pulse too long");
  property p_timer_cause;
    $fell(timer_irq_n) |-> $past(any_tick);
  endproperty
  a_timer_cause: assert property (p_timer_cause) else $error("timer low without tick");
  property p_alarm_hold;
    !alarm_irq_n && !ctrl_wr |=> !alarm_irq_n;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm line let go");
  property p_alarm_off;
    ctrl_wr && !reg_wdata[BIT_ALARM_IRQ_EN] |=> alarm_irq_n;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm not released");
  property p_flag_clr;
    ctrl_wr && !reg_wdata[BIT_ALARM_FLAG] && !$past(any_upd) |=> alarm_irq_n;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear kept line");
  property p_flag_keep;
    !alarm_irq_n && ctrl_wr && reg_wdata[3] && reg_wdata[1] |=> !alarm_irq_n;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("write one cleared");
  property p_alarm_cause;
    $fell(alarm_irq_n) |-> $past(any_upd) || $past(any_upd, 2);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without cause");
  c_pulse: cover property ($rose(timer_irq_n));
  c_alarm: cover property ($fell(alarm_irq_n));
  c_release: cover property (ctrl_wr && !alarm_irq_n);
endmodule // rtc_irq_monitor

bind rtc_timer_alarm_irq rtc_irq_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tick_4096hz(tick_4096hz), .tick_64hz(tick_64hz), .tick_1hz(tick_1hz),
  .tick_1min(tick_1min), .time_upd(time_upd), .int_n_out(int_n_out),
  .int_n_oe_n(int_n_oe_n), .timer_irq_n(timer_irq_n), .alarm_irq_n(alarm_irq_n));

// File: verification/host_model.sv
`timescale 1ns/1ps
module host_model
(
  input  wire logic       clk,       // Clock.
  output logic            reg_wr,    // Write strobe.
  output logic            reg_rd,    // Read strobe.
  output logic      [7:0] reg_addr,  // Offset.
  output logic      [7:0] reg_wdata, // Write data.
  input  wire logic [7:0] reg_rdata  // Read data.
);
  // ---------------------------
  // Register host
  // ---------------------------
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // After the taking edge the bus is inverted so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read data is taken one edge after the strobe was accepted.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule // host_model

// File: verification/rtc_timer_alarm_irq_bench.sv
`timescale 1ns/1ps
module rtc_timer_alarm_irq_bench;
  import rtc_irq_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr, reg_rd, int_n_out, int_n_oe_n, timer_irq_n, alarm_irq_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v, ctl;
  logic [3:0]  ticks = 4'h0;
  logic        time_upd = 1'b0;
  logic [7:0]  new_min = 8'h00, new_hour = 8'h00, new_date = 8'h01, new_wday = 8'h00;
  logic        prev_t = 1'b1;
  logic [15:0] low_len = 16'h0000, last_len = 16'h0000;
  int          n_mismatch = 0, checks_done = 0, n_evt = 0, exp_evt = 0, cycles = 0;
  int          seed = 32'h5db2;
  int          exp_q[$];

  always #10 clk = ~clk;

  rtc_timer_alarm_irq dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tick_4096hz(ticks[0]), .tick_64hz(ticks[1]), .tick_1hz(ticks[2]),
    .tick_1min(ticks[3]), .time_upd(time_upd), .new_min(new_min), .new_hour(new_hour),
    .new_date(new_date), .new_wday(new_wday), .int_n_out(int_n_out),
    .int_n_oe_n(int_n_oe_n), .timer_irq_n(timer_irq_n), .alarm_irq_n(alarm_irq_n));
  host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Counts timer pulses, measures the last one and cuts a hang short.
  always @(posedge clk)
  begin
    low_len <= timer_irq_n ? 16'h0000 : low_len + 16'h0001;
    if (timer_irq_n && low_len != 16'h0000)
    begin
      last_len <= low_len;
      chk(low_len[7:0], (exp_q.size() != 0) ? 8'(exp_q.pop_front()) : 8'hff);
    end
    if (prev_t && !timer_irq_n && !sys_rst)
      n_evt <= n_evt + 1;
    prev_t <= timer_irq_n;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  // ---------------------------
  // Tasks
  // ---------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ticks <= m;
    @(posedge clk);
    ticks <= 4'h0;
  endtask
  // Unmasked minute set as asked; other fields random so masking is exercised.
  task automatic upd(input logic [7:0] m);
    @(posedge clk);
    new_min  <= m;
    new_hour <= 8'($random(seed)) & 8'h13;
    new_date <= 8'($random(seed)) & 8'h27;
    new_wday <= 8'($random(seed)) & 8'h06;
    time_upd <= 1'b1;
    @(posedge clk);
    time_upd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic line_is(input logic e);
    #1;
    chk({6'h00, int_n_oe_n, alarm_irq_n}, {6'h00, e, e});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ---------------------------
  // Main sequence
  // ---------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    host.rd(ADDR_IRQ_CTRL, rd_v);
    chk(rd_v, RST_BYTE);
    host.rd(ADDR_DATE_ALARM, rd_v);
    chk(rd_v, RST_ALARM);
    host.rd(8'h02, rd_v);
    chk(rd_v, 8'h00);
    host.wr(ADDR_MINUTES, 8'hff);
    host.rd(ADDR_MINUTES, rd_v);
    chk(rd_v, MIN_FIELD);
    host.wr(ADDR_IRQ_CTRL, 8'hff);
    host.rd(ADDR_IRQ_CTRL, rd_v);
    chk(rd_v, 8'h13);
    $display("test registers done");
    // Each source in repeat mode; the last one with its interrupt disabled.
    for (int s = 0; s < 4; s++)
    begin
      ctl = (s == 3) ? 8'h10 : 8'h11;
      host.wr(ADDR_TIMER_CTRL, 8'h00);
      host.wr(ADDR_IRQ_CTRL, 8'h00);
      host.wr(ADDR_TIMER_PRE, 8'h02);
      host.wr(ADDR_IRQ_CTRL, ctl);
      host.wr(ADDR_TIMER_CTRL, 8'h80 | 8'(s));
      repeat (2) @(posedge clk);
      pulse(4'($random(seed)) & ~(4'h1 << s));
      for (int k = 0; k < 4; k++)
      begin
        pulse(4'h1 << s);
        if (k % 2 == 1 && s != 3)
          exp_q.push_back(PULSE_HOLD_CYC);
        if (k == 1)
          host.wr(ADDR_IRQ_CTRL, ctl);
        repeat (60) @(posedge clk);
        if (k == 1 && s != 3)
          chk(last_len[7:0], PULSE_HOLD_CYC[7:0]);
      end
      exp_evt = exp_evt + ((s == 3) ? 0 : 2);
      chk(8'(n_evt), 8'(exp_evt));
      host.wr(ADDR_TIMER_CTRL, 8'h00);
      repeat (3) pulse(4'h1 << s);
      repeat (5) @(posedge clk);
      chk(8'(n_evt), 8'(exp_evt));
      host.rd(ADDR_IRQ_CTRL, rd_v);
      chk(rd_v, ctl | 8'h04);
    end
    chk(8'(exp_q.size()), 8'h00);
    $display("test timer done");
    host.wr(ADDR_IRQ_CTRL, 8'h00);
    upd(8'h30);
    host.rd(ADDR_IRQ_CTRL, rd_v);
    chk(rd_v, 8'h00);
    host.wr(ADDR_MIN_ALARM, 8'h30);
    upd(8'h30);
    host.rd(ADDR_IRQ_CTRL, rd_v);
    chk(rd_v, 8'h08);
    line_is(1'b1);
    host.wr(ADDR_IRQ_CTRL, 8'h0a);
    line_is(1'b0);
    upd(8'h30);
    line_is(1'b0);
    host.wr(ADDR_IRQ_CTRL, 8'h02);
    line_is(1'b1);
    upd(8'h30);
    host.rd(ADDR_IRQ_CTRL, rd_v);
    chk(rd_v, 8'h02);
    upd(8'h31);
    upd(8'h30);
    line_is(1'b0);
    host.wr(ADDR_IRQ_CTRL, 8'h08);
    line_is(1'b1);
    $display("test alarm done");
    complete_run();
  end
endmodule // rtc_timer_alarm_irq_bench
